// File: iocem_master_model.sv
`default_nettype none
module iocem_master_model (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Control from the bench.
	input wire logic run,
	input wire logic [7:0] gap,
	input wire logic [7:0] data,
	input wire logic [7:0] inval,
	// Cyclic telegram towards the block.
	output logic bus_telegram,
	output logic [7:0] bus_out_data,
	output logic [7:0] bus_out_invalid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt;

	// Sends a telegram every gap+1 cycles; lines toggle between telegrams.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 8'h00;
			bus_telegram <= 1'b0;
			bus_out_data <= 8'h00;
			bus_out_invalid <= 8'h00;
		end
		else
		begin
			cnt <= (cnt >= gap) ? 8'h00 : cnt + 8'h01;
			bus_telegram <= run && cnt >= gap;
			bus_out_data <= (run && cnt >= gap) ? data : ~bus_out_data;
			bus_out_invalid <= (run && cnt >= gap) ? inval : ~bus_out_invalid;
		end
	end
endmodule : iocem_master_model
`default_nettype wire

// File: iocem_pkg.sv
`default_nettype none
package iocem_pkg;

	localparam int unsigned NCH = 8;

	// Per-channel error mode selection.
	typedef enum logic [1:0] {
		ERR_CURRENT,
		ERR_SUBST,
		ERR_LAST
	} iocem_err_mode_e;

	// Complete register state of the block.
	typedef struct packed {
		logic gsw_en;
		logic unit_active;
		logic [15:0] wd_time;
		logic [7:0] osim_en;
		logic [7:0] osim_val;
		logic [7:0] oinv;
		logic [7:0] osubst;
		logic [15:0] oerr_mode;
		logic [7:0] isim_en;
		logic [15:0] ierr_mode;
		logic [7:0][15:0] isim_val;
		logic [7:0][15:0] isubst;
		logic [7:0] ohold;
		logic [7:0] ohold_inv;
		logic [7:0] olast;
		logic out_live;
		logic [16:0] tick_cnt;
		logic tick;
		logic [15:0] wd_cnt;
		logic wd_expired;
		logic [9:0] link_cnt;
		logic link_lost;
		logic [7:0][15:0] ilast;
		logic [7:0][15:0] in_val;
		logic [7:0] in_inval;
		logic [7:0] drive;
		logic [7:0] drv_en;
		logic [15:0] gsw;
	} iocem_state_s;

endpackage : iocem_pkg
`default_nettype wire

// File: iocem_properties.sv
`default_nettype none
module iocem_properties #(
	parameter int TICK_CYCLES = 10
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Watched ports.
	input wire logic module_link_ok,
	input wire logic [5:0] psu_fault,
	input wire logic [7:0] chan_out_en,
	input wire logic [15:0] gsw_word,
	input wire logic [7:0] cyc_in_invalid,
	input wire logic slot_alarm
);
	timeunit 1ns;
	timeprecision 1ps;
	// Margin covers the free-running tick phase and the output register.
	localparam int LINK_MIN = 499 * TICK_CYCLES;
	localparam int LINK_MAX = 501 * TICK_CYCLES + 4;
	int lo_cnt;

	////////////////////////////////////////////////////////////////////////
	// Counts cycles since the module link was last seen alive.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lo_cnt <= 0;
		else
			lo_cnt <= module_link_ok ? 0 : lo_cnt + 1;
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_link_off: assert property (slot_alarm |-> chan_out_en == 8'h00)
		else $error("outputs active after link loss");
	a_link_inval: assert property (slot_alarm |-> cyc_in_invalid == 8'hFF)
		else $error("inputs valid after link loss");
	a_link_early: assert property ($rose(slot_alarm) |-> lo_cnt >= LINK_MIN)
		else $error("link alarm too early");
	a_link_late: assert property (lo_cnt >= LINK_MAX |-> slot_alarm)
		else $error("link alarm too late");
	a_en_fall: assert property ($fell(chan_out_en[0]) |-> slot_alarm)
		else $error("output switched off without link loss");
	a_fault_code: assert property (gsw_word[13] == (gsw_word[11:8] != 4'h0))
		else $error("fault bit disagrees with error code");
	a_mod_code: assert property (gsw_word[12] |-> gsw_word[11:8] == 4'h6)
		else $error("module fault without module code");
	a_psu_bits: assert property (gsw_word[11:8] == 4'h7 && !gsw_word[7]
		|-> gsw_word[5:0] == $past(psu_fault)) else $error("supply bits wrong");
endmodule : iocem_properties

bind iocem_top iocem_properties #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
	.pclk(pclk), .presetn(presetn), .module_link_ok(module_link_ok),
	.psu_fault(psu_fault), .chan_out_en(chan_out_en), .gsw_word(gsw_word),
	.cyc_in_invalid(cyc_in_invalid), .slot_alarm(slot_alarm));
`default_nettype wire

// File: iocem_regs.svh
// What this block does
// RULE1: Simulation affects only its own channel.
// RULE2: Simulated input reports its preset value.
// RULE3: Simulated output passes through inversion too.
// RULE4: Normal output drives the bus bit directly.
// RULE5: Inversion complements the selected output bit.
// RULE6: Every channel is selected on its own.
// RULE7: A fault applies the channel's error mode.
// RULE8: Watchdog expiry or invalid flag means error.
// RULE9: Watchdog time zero disables the watchdog.
// RULE10: Start-up fault moves outputs to substitute.
// RULE11: Current mode keeps driving the invalid value.
// RULE12: Fixed substitute accepts only in-range values.
// RULE13: Last-valid mode drives the stored good value.
// RULE14: Module link loss disables outputs after 500 ms.
// RULE15: Input fault reports the error-mode value.
// RULE16: Current mode input reports faulty value, invalid.
// RULE17: Fixed substitute input is always marked invalid.
// RULE18: Last-valid input reports stored value, invalid.
// RULE19: Link loss marks inputs invalid, sets alarm.
// RULE20: Two-byte global status word leads cyclic input.
// RULE21: A setting includes or drops the status word.
// RULE22: Status bits 15 to 12 give state.
// RULE23: Bits 11-8 code, bit 7 multiple, 5-0 slot.
// RULE24: Watchdog restarts on each valid telegram.
`ifndef IOCEM_REGS_SVH
`define IOCEM_REGS_SVH

// Register byte offsets.
`define IOCEM_OFS_CTRL 12'h000
`define IOCEM_OFS_WDOG 12'h004
`define IOCEM_OFS_OSIM_EN 12'h008
`define IOCEM_OFS_OSIM_VAL 12'h00C
`define IOCEM_OFS_OINV 12'h010
`define IOCEM_OFS_OSUBST 12'h014
`define IOCEM_OFS_OERR_MODE 12'h018
`define IOCEM_OFS_ISIM_EN 12'h01C
`define IOCEM_OFS_IERR_MODE 12'h020
`define IOCEM_OFS_STATUS 12'h024
`define IOCEM_OFS_GSW 12'h028
`define IOCEM_OFS_IN_INVALID 12'h02C
`define IOCEM_OFS_ISIM_VAL 12'h040
`define IOCEM_OFS_ISUBST 12'h060

// Control register fields.
`define IOCEM_CTRL_GSW_EN 0
`define IOCEM_CTRL_ACTIVE 1

// Global status word fields and codes.
`define IOCEM_GSW_ACTIVE 15
`define IOCEM_GSW_SIM 14
`define IOCEM_GSW_FAULT 13
`define IOCEM_GSW_MODFLT 12
`define IOCEM_GSW_MULTI 7
`define IOCEM_GSW_PARAM 6
`define IOCEM_CODE_MODULE 4'h6
`define IOCEM_CODE_PSU 4'h7

// Upper bound of the input operating range (overrange included).
`define IOCEM_IN_RANGE_MAX 16'hEA60

// Timing: base tick and link watchdog.
`define IOCEM_CLK_NS 10
`define IOCEM_TICK_NS 1000000
`define IOCEM_TICK_CYCLES (`IOCEM_TICK_NS / `IOCEM_CLK_NS)
`define IOCEM_LINK_WD_MS 500

`endif

// File: iocem_top.sv
`include "iocem_regs.svh"
`default_nettype none
module iocem_top #(
	parameter int TICK_CYCLES = `IOCEM_TICK_CYCLES
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Cyclic output data from the fieldbus master.
	input wire logic bus_telegram,
	input wire logic [7:0] bus_out_data,
	input wire logic [7:0] bus_out_invalid,
	// Output channels.
	output logic [7:0] chan_out,
	output logic [7:0] chan_out_en,
	// Input channels from the I/O module.
	input wire logic module_link_ok,
	input wire logic [127:0] field_in_value,
	input wire logic [7:0] field_in_fault,
	// Unit status sources.
	input wire logic [3:0] unit_err_code,
	input wire logic [5:0] psu_fault,
	input wire logic [5:0] module_slot,
	input wire logic param_busy,
	// Cyclic input data towards the master.
	output logic gsw_present,
	output logic [15:0] gsw_word,
	output logic [127:0] cyc_in_value,
	output logic [7:0] cyc_in_invalid,
	output logic slot_alarm
);

	iocem_pkg::iocem_state_s s_ff;
	iocem_pkg::iocem_state_s nxt_s;

	logic wr_en;
	logic rd_en;
	logic unmapped;
	logic bad_range;
	logic [2:0] idx;
	logic mod_fault;
	logic [3:0] nerr;

	// Picks a channel's two-bit error mode out of a packed field.
	function automatic iocem_pkg::iocem_err_mode_e mode_of(
		input logic [15:0] field,
		input int ch
	);
		logic [1:0] m;
		m = field[2*ch +: 2];
		mode_of = iocem_pkg::iocem_err_mode_e'(m);
	endfunction : mode_of

	// True when an address lies in an eight-word channel array.
	function automatic logic in_array(
		input logic [11:0] addr,
		input logic [11:0] base
	);
		in_array = (addr[11:5] == base[11:5]);
	endfunction : in_array

	////////////////////////////////////////////////////////////////////
	// Bus decode.

	// Slave answers at once; errors flag unmapped accesses or rejected writes.
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign idx = paddr[4:2];
	assign pready = 1'b1;
	assign pslverr = psel & penable & (unmapped | (pwrite & bad_range));

	// Rejects an input substitute outside the operating range.
	assign bad_range = in_array(paddr, `IOCEM_OFS_ISUBST) &&
		(pwdata[15:0] > `IOCEM_IN_RANGE_MAX); // [RULE12]

	// Address map and read data.
	always_comb
	begin
		unmapped = 1'b0;
		prdata = 32'h0000_0000;
		if (in_array(paddr, `IOCEM_OFS_ISIM_VAL))
			prdata = {16'h0000, s_ff.isim_val[idx]};
		else if (in_array(paddr, `IOCEM_OFS_ISUBST))
			prdata = {16'h0000, s_ff.isubst[idx]};
		else
		begin
			case (paddr)
			`IOCEM_OFS_CTRL: prdata = {30'h0, s_ff.unit_active, s_ff.gsw_en};
			`IOCEM_OFS_WDOG: prdata = {16'h0000, s_ff.wd_time};
			`IOCEM_OFS_OSIM_EN: prdata = {24'h00_0000, s_ff.osim_en};
			`IOCEM_OFS_OSIM_VAL: prdata = {24'h00_0000, s_ff.osim_val};
			`IOCEM_OFS_OINV: prdata = {24'h00_0000, s_ff.oinv};
			`IOCEM_OFS_OSUBST: prdata = {24'h00_0000, s_ff.osubst};
			`IOCEM_OFS_OERR_MODE: prdata = {16'h0000, s_ff.oerr_mode};
			`IOCEM_OFS_ISIM_EN: prdata = {24'h00_0000, s_ff.isim_en};
			`IOCEM_OFS_IERR_MODE: prdata = {16'h0000, s_ff.ierr_mode};
			`IOCEM_OFS_STATUS: prdata = {13'h0000, s_ff.out_live,
				s_ff.link_lost, s_ff.wd_expired, s_ff.drv_en, s_ff.drive};
			`IOCEM_OFS_GSW: prdata = {16'h0000, s_ff.gsw};
			`IOCEM_OFS_IN_INVALID: prdata = {24'h00_0000, s_ff.in_inval};
			default: unmapped = 1'b1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Status word sources.

	// Module fault counts once; each supply fault counts once.
	always_comb
	begin
		mod_fault = s_ff.link_lost | (|field_in_fault);
		nerr = 4'(unit_err_code != 4'h0) + 4'(mod_fault) +
			4'($countones(psu_fault));
	end

	////////////////////////////////////////////////////////////////////
	// Next state.

	// Register writes, timers, channel selection and status word.
	always_comb
	begin
		nxt_s = s_ff;
		// Register writes.
		if (wr_en && !unmapped && !bad_range)
		begin
			if (in_array(paddr, `IOCEM_OFS_ISIM_VAL))
				nxt_s.isim_val[idx] = pwdata[15:0];
			else if (in_array(paddr, `IOCEM_OFS_ISUBST))
				nxt_s.isubst[idx] = pwdata[15:0]; // [RULE12]
			else
			begin
				case (paddr)
				`IOCEM_OFS_CTRL:
				begin
					nxt_s.gsw_en = pwdata[`IOCEM_CTRL_GSW_EN]; // [RULE21]
					nxt_s.unit_active = pwdata[`IOCEM_CTRL_ACTIVE];
				end
				`IOCEM_OFS_WDOG: nxt_s.wd_time = pwdata[15:0];
				`IOCEM_OFS_OSIM_EN: nxt_s.osim_en = pwdata[7:0];
				`IOCEM_OFS_OSIM_VAL: nxt_s.osim_val = pwdata[7:0];
				`IOCEM_OFS_OINV: nxt_s.oinv = pwdata[7:0];
				`IOCEM_OFS_OSUBST: nxt_s.osubst = pwdata[7:0];
				`IOCEM_OFS_OERR_MODE: nxt_s.oerr_mode = pwdata[15:0];
				`IOCEM_OFS_ISIM_EN: nxt_s.isim_en = pwdata[7:0];
				`IOCEM_OFS_IERR_MODE: nxt_s.ierr_mode = pwdata[15:0];
				default: ;
				endcase
			end
		end

		// One-millisecond tick divider.
		nxt_s.tick = 1'b0;
		if (s_ff.tick_cnt >= 17'(TICK_CYCLES - 1))
		begin
			nxt_s.tick_cnt = 17'h0_0000;
			nxt_s.tick = 1'b1;
		end
		else
			nxt_s.tick_cnt = s_ff.tick_cnt + 17'h0_0001;

		// Master watchdog; zero time keeps it off.
		if (bus_telegram)
		begin
			nxt_s.wd_cnt = 16'h0000; // [RULE24]
			nxt_s.wd_expired = 1'b0; // [RULE24]
			nxt_s.out_live = 1'b1;
			nxt_s.ohold = bus_out_data;
			nxt_s.ohold_inv = bus_out_invalid;
			for (int c = 0; c < 8; c++)
				if (!bus_out_invalid[c])
					nxt_s.olast[c] = bus_out_data[c]; // [RULE13]
		end
		else if (s_ff.wd_time == 16'h0000)
			nxt_s.wd_expired = 1'b0; // [RULE9]
		else if (s_ff.tick && !s_ff.wd_expired)
		begin
			if (s_ff.wd_cnt + 16'h0001 >= s_ff.wd_time)
			begin
				nxt_s.wd_expired = 1'b1; // [RULE24]
				nxt_s.out_live = 1'b1; // [RULE10]
			end
			else
				nxt_s.wd_cnt = s_ff.wd_cnt + 16'h0001;
		end

		// Module link watchdog.
		if (module_link_ok)
		begin
			nxt_s.link_cnt = 10'h000;
			nxt_s.link_lost = 1'b0;
		end
		else if (s_ff.tick && !s_ff.link_lost)
		begin
			if (s_ff.link_cnt + 10'h001 >= 10'(`IOCEM_LINK_WD_MS))
				nxt_s.link_lost = 1'b1; // [RULE14]
			else
				nxt_s.link_cnt = s_ff.link_cnt + 10'h001;
		end

		// Output channels, each on its own.
		for (int c = 0; c < 8; c++) // [RULE6]
		begin
			logic sel;
			logic err;
			sel = s_ff.ohold[c]; // [RULE4]
			err = s_ff.ohold_inv[c] | s_ff.wd_expired; // [RULE8]
			if (err)
			begin
				case (mode_of(s_ff.oerr_mode, c)) // [RULE7]
				iocem_pkg::ERR_SUBST: sel = s_ff.osubst[c]; // [RULE12]
				iocem_pkg::ERR_LAST: sel = s_ff.olast[c]; // [RULE13]
				default: sel = s_ff.ohold[c]; // [RULE11]
				endcase
			end
			if (s_ff.osim_en[c])
				sel = s_ff.osim_val[c]; // [RULE1] [RULE3]
			nxt_s.drive[c] = nxt_s.out_live & (sel ^ s_ff.oinv[c]); // [RULE5]
			nxt_s.drv_en[c] = nxt_s.out_live & ~nxt_s.link_lost; // [RULE14]
		end

		// Input channels, each on its own.
		for (int c = 0; c < 8; c++) // [RULE6]
		begin
			logic [15:0] meas;
			meas = field_in_value[16*c +: 16];
			nxt_s.in_val[c] = meas;
			nxt_s.in_inval[c] = 1'b0;
			if (field_in_fault[c])
			begin
				nxt_s.in_inval[c] = 1'b1; // [RULE15]
				case (mode_of(s_ff.ierr_mode, c)) // [RULE7]
				iocem_pkg::ERR_SUBST: nxt_s.in_val[c] = s_ff.isubst[c]; // [RULE17]
				iocem_pkg::ERR_LAST: nxt_s.in_val[c] = s_ff.ilast[c]; // [RULE18]
				default: nxt_s.in_val[c] = meas; // [RULE16]
				endcase
			end
			else if (!s_ff.link_lost)
				nxt_s.ilast[c] = meas;
			if (s_ff.isim_en[c])
			begin
				nxt_s.in_val[c] = s_ff.isim_val[c]; // [RULE1] [RULE2]
				nxt_s.in_inval[c] = 1'b0;
			end
			// A lost link beats simulation and rises with the slot alarm.
			if (nxt_s.link_lost)
				nxt_s.in_inval[c] = 1'b1; // [RULE19]
		end

		// Global status word.
		nxt_s.gsw = 16'h0000;
		nxt_s.gsw[`IOCEM_GSW_ACTIVE] = s_ff.unit_active; // [RULE22]
		nxt_s.gsw[`IOCEM_GSW_SIM] = |{s_ff.osim_en, s_ff.isim_en}; // [RULE22]
		nxt_s.gsw[`IOCEM_GSW_FAULT] = (nerr != 4'h0); // [RULE22]
		nxt_s.gsw[`IOCEM_GSW_PARAM] = param_busy;
		if (unit_err_code == 4'h0 && !mod_fault && psu_fault != 6'h00)
		begin
			nxt_s.gsw[11:8] = `IOCEM_CODE_PSU; // [RULE23]
			nxt_s.gsw[5:0] = psu_fault;
		end
		else if (nerr > 4'h1)
		begin
			nxt_s.gsw[`IOCEM_GSW_MULTI] = 1'b1; // [RULE23]
			nxt_s.gsw[5:0] = {2'b00, nerr};
			nxt_s.gsw[`IOCEM_GSW_MODFLT] = mod_fault;
			nxt_s.gsw[11:8] = mod_fault ? `IOCEM_CODE_MODULE : unit_err_code;
		end
		else if (mod_fault)
		begin
			nxt_s.gsw[`IOCEM_GSW_MODFLT] = 1'b1; // [RULE22]
			nxt_s.gsw[11:8] = `IOCEM_CODE_MODULE;
			nxt_s.gsw[5:0] = module_slot; // [RULE23]
		end
		else
			nxt_s.gsw[11:8] = unit_err_code;
	end

	////////////////////////////////////////////////////////////////////
	// State register.

	// All state resets to powered-off, watchdog idle, no simulation.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	////////////////////////////////////////////////////////////////////
	// Outputs.

	// Cyclic data leaves straight from the state register.
	assign chan_out = s_ff.drive;
	assign chan_out_en = s_ff.drv_en;
	assign gsw_present = s_ff.gsw_en; // [RULE20] [RULE21]
	assign gsw_word = s_ff.gsw; // [RULE20]
	assign cyc_in_value = s_ff.in_val;
	assign cyc_in_invalid = s_ff.in_inval;
	assign slot_alarm = s_ff.link_lost; // [RULE19]

endmodule : iocem_top
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, er, bus_telegram, module_link_ok = 1;
	logic [7:0] bus_out_data, bus_out_invalid, chan_out, chan_out_en;
	logic [7:0] cyc_in_invalid, md = 0, mi = 0, field_in_fault = 0, gap = 3;
	logic [127:0] field_in_value = 0, cyc_in_value;
	logic [5:0] psu_fault = 0, module_slot = 0;
	logic [3:0] unit_err_code = 0;
	logic param_busy = 0;
	logic [15:0] gsw_word;
	logic gsw_present, slot_alarm;
	int n_mismatch = 0, tests_run = 0;

	// Free-running 100 MHz clock.
	always #5 pclk = ~pclk;

	iocem_top #(.TICK_CYCLES(10)) dut_u (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_telegram,
		.bus_out_data, .bus_out_invalid, .chan_out, .chan_out_en,
		.module_link_ok, .field_in_value, .field_in_fault,
		.unit_err_code, .psu_fault, .module_slot,
		.param_busy, .gsw_present, .gsw_word, .cyc_in_value,
		.cyc_in_invalid, .slot_alarm);
	iocem_master_model mst_u (.pclk, .presetn, .run, .gap, .data(md),
		.inval(mi), .bus_telegram, .bus_out_data, .bus_out_invalid);

	////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask : wt

	// One APB transfer; holds the request until pready is seen.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb

	task automatic chk(input logic [127:0] g, input logic [127:0] e);
		tests_run++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected at %0t: exp %0h got %0h", $time, e, g);
		end
	endtask : chk

	////////////////////////////////////////////////////////////////////////
	// Main sequence of tests.
	initial
	begin
		wt(3);
		presetn <= 1;
		apb(0, 12'h3FC, 0);
		chk(chan_out_en, 0);
		chk({er, rd}, 33'h1_0000_0000);
		$display("test reset done");
		apb(1, 12'h010, 32'h0000_000F);
		md <= 8'h5A;
		run <= 1;
		wt(12);
		chk(chan_out_en, 8'hFF);
		chk(chan_out, 8'h55);
		apb(1, 12'h010, 0);
		apb(1, 12'h018, 32'h0000_0A50);
		apb(1, 12'h014, 32'h0000_0004);
		md <= 8'h30;
		wt(12);
		md <= 8'h0F;
		mi <= 8'hFF;
		wt(12);
		chk(chan_out, 8'h37);
		apb(1, 12'h010, 32'h0000_0005);
		wt(3);
		chk(chan_out, 8'h32);
		$display("test error modes done");
		mi <= 0;
		md <= 8'h02;
		apb(1, 12'h010, 1);
		apb(1, 12'h008, 1);
		apb(1, 12'h00C, 1);
		wt(12);
		chk(chan_out, 8'h02);
		$display("test simulation done");
		apb(1, 12'h004, 2);
		run <= 0;
		wt(50);
		apb(0, 12'h024, 0);
		chk(rd[16], 1);
		apb(1, 12'h004, 0);
		gap <= 20;
		run <= 1;
		wt(30);
		run <= 0;
		wt(60);
		apb(0, 12'h024, 0);
		chk(rd[16], 0);
		gap <= 3;
		run <= 1;
		$display("test watchdog done");
		apb(1, 12'h020, 32'h0000_0024);
		apb(1, 12'h064, 32'h0000_1234);
		apb(1, 12'h01C, 32'h0000_0008);
		apb(1, 12'h04C, 32'h0000_0777);
		field_in_value <= {8{16'h1111}};
		wt(4);
		field_in_value <= {8{16'h2222}};
		field_in_fault <= 8'h07;
		wt(4);
		chk(cyc_in_value[63:0], 64'h0777_1111_1234_2222);
		chk(cyc_in_invalid, 8'h07);
		apb(1, 12'h064, 32'h0000_EA61);
		chk(er, 1);
		apb(0, 12'h064, 0);
		chk(rd, 32'h0000_1234);
		field_in_fault <= 0;
		$display("test inputs done");
		apb(1, 12'h000, 3);
		psu_fault <= 6'h05;
		wt(4);
		chk({gsw_present, gsw_word}, 17'h1_E705);
		psu_fault <= 0;
		module_slot <= 6'h04;
		field_in_fault <= 8'h10;
		param_busy <= 1;
		wt(4);
		chk(gsw_word, 16'hF644);
		unit_err_code <= 4'h3;
		wt(4);
		chk(gsw_word, 16'hF6C2);
		unit_err_code <= 0;
		field_in_fault <= 0;
		param_busy <= 0;
		apb(1, 12'h000, 0);
		wt(2);
		chk(gsw_present, 0);
		$display("test status word done");
		module_link_ok <= 0;
		wt(5100);
		chk({slot_alarm, chan_out_en, cyc_in_invalid}, 17'h1_00FF);
		$display("test link loss done");
		end_sim();
	end

	// Cuts a hang short well after the expected run length.
	initial
	begin
		#100000;
		n_mismatch++;
		end_sim();
	end
endmodule : testbench
`default_nettype wire
